// >>> design/shared_parallel_io_ports.sv
`timescale 1ns/1ps
// Summary of operation
// - Enabled, driving peripheral takes the pad; port driver off, pin readable.
// - Enabled peripheral not driving leaves the pad to latch and direction.
// - Direction one makes an input, zero drives the latch onto the pin.
// - Reset sets every implemented direction bit to one.
// - Latch register reads the latch and writes update it.
// - Pin-level register reads sampled pins; writes go to the latch.
// - Unimplemented bits read zero in latch, direction and pin level.
// - Pins shared only with input peripherals stay fully under port control.
// - Two muxes per pin pick data and enable, peripheral first.
// - Analog-configured pins read zero in the pin-level register.
module shared_parallel_io_ports (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] pad_b_in_i,
  input  wire logic [15:0] pad_c_in_i,
  input  wire logic [15:0] pad_d_in_i,
  input  wire logic [15:0] pad_e_in_i,
  input  wire logic [15:0] pad_f_in_i,
  output logic      [15:0] pad_b_out_o,
  output logic      [15:0] pad_c_out_o,
  output logic      [15:0] pad_d_out_o,
  output logic      [15:0] pad_e_out_o,
  output logic      [15:0] pad_f_out_o,
  output logic      [15:0] pad_b_oe_o,
  output logic      [15:0] pad_c_oe_o,
  output logic      [15:0] pad_d_oe_o,
  output logic      [15:0] pad_e_oe_o,
  output logic      [15:0] pad_f_oe_o,
  input  wire logic [15:0] periph_b_en_i,
  input  wire logic [15:0] periph_c_en_i,
  input  wire logic [15:0] periph_d_en_i,
  input  wire logic [15:0] periph_e_en_i,
  input  wire logic [15:0] periph_f_en_i,
  input  wire logic [15:0] periph_b_drive_i,
  input  wire logic [15:0] periph_c_drive_i,
  input  wire logic [15:0] periph_d_drive_i,
  input  wire logic [15:0] periph_e_drive_i,
  input  wire logic [15:0] periph_f_drive_i,
  input  wire logic [15:0] periph_b_out_i,
  input  wire logic [15:0] periph_c_out_i,
  input  wire logic [15:0] periph_d_out_i,
  input  wire logic [15:0] periph_e_out_i,
  input  wire logic [15:0] periph_f_out_i,
  output logic      [15:0] pin_b_level_o,
  output logic      [15:0] pin_c_level_o,
  output logic      [15:0] pin_d_level_o,
  output logic      [15:0] pin_e_level_o,
  output logic      [15:0] pin_f_level_o
);

  localparam int NP = gpio_pkg::NPORT;

  logic [15:0] pad_in     [NP];
  logic [15:0] pad_out    [NP];
  logic [15:0] pad_oe     [NP];
  logic [15:0] per_en     [NP];
  logic [15:0] per_drive  [NP];
  logic [15:0] per_out    [NP];
  logic [15:0] dir        [NP];
  logic [15:0] lat        [NP];
  logic [15:0] pin_lvl    [NP];
  logic [15:0] pin_rd     [NP];
  logic [NP-1:0] dir_wr;
  logic [NP-1:0] lat_wr;

  logic        req;
  logic        wr_go;
  logic        ack_q;
  logic [15:0] rd_d;
  logic [15:0] rd_q;
  logic [15:0] ana_q;

  assign pad_in[0] = pad_b_in_i;
  assign pad_in[1] = pad_c_in_i;
  assign pad_in[2] = pad_d_in_i;
  assign pad_in[3] = pad_e_in_i;
  assign pad_in[4] = pad_f_in_i;

  assign per_en[0] = periph_b_en_i;
  assign per_en[1] = periph_c_en_i;
  assign per_en[2] = periph_d_en_i;
  assign per_en[3] = periph_e_en_i;
  assign per_en[4] = periph_f_en_i;

  assign per_drive[0] = periph_b_drive_i;
  assign per_drive[1] = periph_c_drive_i;
  assign per_drive[2] = periph_d_drive_i;
  assign per_drive[3] = periph_e_drive_i;
  assign per_drive[4] = periph_f_drive_i;

  assign per_out[0] = periph_b_out_i;
  assign per_out[1] = periph_c_out_i;
  assign per_out[2] = periph_d_out_i;
  assign per_out[3] = periph_e_out_i;
  assign per_out[4] = periph_f_out_i;

  assign pad_b_out_o = pad_out[0];
  assign pad_c_out_o = pad_out[1];
  assign pad_d_out_o = pad_out[2];
  assign pad_e_out_o = pad_out[3];
  assign pad_f_out_o = pad_out[4];

  assign pad_b_oe_o = pad_oe[0];
  assign pad_c_oe_o = pad_oe[1];
  assign pad_d_oe_o = pad_oe[2];
  assign pad_e_oe_o = pad_oe[3];
  assign pad_f_oe_o = pad_oe[4];

  // Pin levels go to peripherals even while a peripheral drives the pad
  assign pin_b_level_o = pin_lvl[0];
  assign pin_c_level_o = pin_lvl[1];
  assign pin_d_level_o = pin_lvl[2];
  assign pin_e_level_o = pin_lvl[3];
  assign pin_f_level_o = pin_lvl[4];

  // Bus slave: one wait state, ack for one cycle, write at the ack edge
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_q <= 16'h0000;
    end
    else if (req & ~ack_q)
    begin
      rd_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {16'h0000, rd_q};

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ana_q <= gpio_pkg::ANA_RST;
    end
    else if (wr_go & gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::ANA_IDX))
    begin
      ana_q <= gpio_pkg::byte_merge(ana_q, wb_dat_i[15:0], wb_sel_i[1:0]) &
               gpio_pkg::IMPL_MASK[gpio_pkg::ANA_PORT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      assign dir_wr[g] = wr_go &
        gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::DIR_IDX[g]);
      assign lat_wr[g] = wr_go &
        (gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::LAT_IDX[g]) |
         gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::PIN_IDX[g]));

      // Analog pins read low, unimplemented bits read zero
      if (g == gpio_pkg::ANA_PORT)
      begin : g_ana
        assign pin_rd[g] = pin_lvl[g] & gpio_pkg::IMPL_MASK[g] &
                           ~ana_q;
      end
      else
      begin : g_dig
        assign pin_rd[g] = pin_lvl[g] & gpio_pkg::IMPL_MASK[g];
      end

      pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pad_i   (pad_in[g]),
        .level_o (pin_lvl[g])
      );

      port_slice #(
        .IMPL    (gpio_pkg::IMPL_MASK[g]),
        .OUT_CAP (gpio_pkg::OUT_CAP_MASK[g])
      ) u_port (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .dir_wr_i       (dir_wr[g]),
        .lat_wr_i       (lat_wr[g]),
        .wdata_i        (wb_dat_i[15:0]),
        .sel_i          (wb_sel_i[1:0]),
        .periph_en_i    (per_en[g]),
        .periph_drive_i (per_drive[g]),
        .periph_out_i   (per_out[g]),
        .dir_o          (dir[g]),
        .lat_o          (lat[g]),
        .pad_out_o      (pad_out[g]),
        .pad_oe_o       (pad_oe[g])
      );

      property p_lat_read;
        @(posedge clk_i) disable iff (!rst_n_i)
          (req & ~ack_q & ~wb_we_i &
           gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::LAT_IDX[g]))
          |=> wb_ack_o && (rd_q == $past(lat[g]));
      endproperty
      a_lat_read: assert property (p_lat_read)
        else $error("latch read returned wrong value");

      property p_pin_write;
        @(posedge clk_i) disable iff (!rst_n_i)
          (wr_go & (wb_sel_i[1:0] == 2'b11) &
           gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::PIN_IDX[g]))
          |=> (lat[g] == ($past(wb_dat_i[15:0]) & gpio_pkg::IMPL_MASK[g]));
      endproperty
      a_pin_write: assert property (p_pin_write)
        else $error("pin-level write missed the latch");

      property p_pin_read;
        @(posedge clk_i) disable iff (!rst_n_i)
          (req & ~ack_q & ~wb_we_i &
           gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::PIN_IDX[g]))
          |=> (rd_q == $past(pin_rd[g]));
      endproperty
      a_pin_read: assert property (p_pin_read)
        else $error("pin-level read returned wrong value");

      property p_unimpl_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
          (((dir[g] | lat[g] | pin_rd[g]) &
            ~gpio_pkg::IMPL_MASK[g]) == 16'h0000);
      endproperty
      a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit reads nonzero");

      property p_dir_read;
        @(posedge clk_i) disable iff (!rst_n_i)
          (req & ~ack_q & ~wb_we_i &
           gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::DIR_IDX[g]))
          |=> (wb_dat_o == {16'h0000, $past(dir[g])});
      endproperty
      a_dir_read: assert property (p_dir_read)
        else $error("direction read returned wrong value");
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_d = 16'h0000;
    for (int p = 0; p < NP; p++)
    begin
      if (gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::DIR_IDX[p]))
      begin
        rd_d = dir[p];
      end
      if (gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::PIN_IDX[p]))
      begin
        rd_d = pin_rd[p];
      end
      if (gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::LAT_IDX[p]))
      begin
        rd_d = lat[p];
      end
    end
    if (gpio_pkg::reg_hit(wb_adr_i, gpio_pkg::ANA_IDX))
    begin
      rd_d = ana_q;
    end
  end

  property p_ack_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_ack_timing;
    @(posedge clk_i) disable iff (!rst_n_i)
      (req & ~ack_q) |=> wb_ack_o;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("ack not one cycle after request");

  property p_analog_low;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((pin_rd[gpio_pkg::ANA_PORT] & ana_q) == 16'h0000);
  endproperty
  a_analog_low: assert property (p_analog_low)
    else $error("analog pin reads high");

  // Synchroniser restarts from zero, so skip the cycles just after reset
  property p_sample_path;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i, 5) && $past(rst_n_i, 4) && $past(rst_n_i, 3) &&
      $past(rst_n_i, 2) && $past(rst_n_i) &&
      ($past(pad_in[0], 5) == $past(pad_in[0], 4)) &&
      ($past(pad_in[0], 4) == $past(pad_in[0], 3))
      |-> (pin_lvl[0] == $past(pad_in[0], 3));
  endproperty
  a_sample_path: assert property (p_sample_path)
    else $error("stable pad not reflected in pin level");

endmodule

// >>> design/gpio_pkg.sv
package gpio_pkg;

  localparam int NPORT = 5;
  localparam int REG_W = 16;
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] DIR_IDX [NPORT] =
    '{10'h2C6, 10'h2CC, 10'h2D2, 10'h2D8, 10'h2DE};
  localparam logic [IDX_W-1:0] PIN_IDX [NPORT] =
    '{10'h2C8, 10'h2CE, 10'h2D4, 10'h2DA, 10'h2E0};
  localparam logic [IDX_W-1:0] LAT_IDX [NPORT] =
    '{10'h2CA, 10'h2D0, 10'h2D6, 10'h2DC, 10'h2E2};
  localparam logic [IDX_W-1:0] ANA_IDX = 10'h2E4;

  // Implemented pins per port, ports B..F
  localparam logic [REG_W-1:0] IMPL_MASK [NPORT] =
    '{16'h01FF, 16'hE000, 16'h000F, 16'h013F, 16'h007F};
  // Pins whose peripheral may drive; same as IMPL_MASK, so no pin is cleared as input-only
  localparam logic [REG_W-1:0] OUT_CAP_MASK [NPORT] =
    '{16'h01FF, 16'hE000, 16'h000F, 16'h013F, 16'h007F};

  localparam logic [REG_W-1:0] LAT_RST = 16'h0000;
  localparam logic [REG_W-1:0] ANA_RST = 16'h0000;
  localparam int               ANA_PORT = 0;
  localparam int               SYNC_STAGES = 3;

  function automatic logic [REG_W-1:0] byte_merge(
    input logic [REG_W-1:0] old_v,
    input logic [REG_W-1:0] new_v,
    input logic [1:0]       sel
  );
    byte_merge = old_v;
    if (sel[0])
    begin
      byte_merge[7:0] = new_v[7:0];
    end
    if (sel[1])
    begin
      byte_merge[15:8] = new_v[15:8];
    end
  endfunction

  function automatic logic reg_hit(
    input logic [ADR_W-1:0] adr,
    input logic [IDX_W-1:0] idx
  );
    reg_hit = (adr[ADR_W-1:2] == idx);
  endfunction

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] pad_i,
  output logic      [15:0] level_o
);

  logic [15:0] s1_q;
  logic [15:0] s2_q;
  logic [15:0] s3_q;
  logic [15:0] level_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end
    else
    begin
      s1_q <= pad_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      level_q <= 16'h0000;
    end
    else
    begin
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end

  assign level_o = level_q;

endmodule

// >>> design/port_slice.sv
`timescale 1ns/1ps
module port_slice #(
  parameter logic [15:0] IMPL    = 16'h0000,
  parameter logic [15:0] OUT_CAP = 16'h0000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        dir_wr_i,
  input  wire logic        lat_wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [15:0] periph_en_i,
  input  wire logic [15:0] periph_drive_i,
  input  wire logic [15:0] periph_out_i,
  output logic      [15:0] dir_o,
  output logic      [15:0] lat_o,
  output logic      [15:0] pad_out_o,
  output logic      [15:0] pad_oe_o
);

  logic [15:0] dir_q;
  logic [15:0] lat_q;
  logic [15:0] own;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dir_q <= IMPL;
    end
    else if (dir_wr_i)
    begin
      dir_q <= gpio_pkg::byte_merge(dir_q, wdata_i, sel_i) & IMPL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lat_q <= gpio_pkg::LAT_RST;
    end
    else if (lat_wr_i)
    begin
      lat_q <= gpio_pkg::byte_merge(lat_q, wdata_i, sel_i) & IMPL;
    end
  end

  // Peripheral owns a pad only when enabled, driving and output capable
  assign own = periph_en_i & periph_drive_i & OUT_CAP & IMPL;

  assign pad_oe_o  = own | (~own & ~dir_q & IMPL);
  assign pad_out_o = (own & periph_out_i) | (~own & lat_q & IMPL);
  assign dir_o     = dir_q;
  assign lat_o     = lat_q;

  property p_periph_owns;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((own & ~pad_oe_o) == 16'h0000) &&
      ((own & (pad_out_o ^ periph_out_i)) == 16'h0000);
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("peripheral does not own its pad");

  property p_port_drives;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((~own & (pad_oe_o ^ (~dir_q & IMPL))) == 16'h0000);
  endproperty
  a_port_drives: assert property (p_port_drives)
    else $error("port lost control of idle shared pad");

  property p_dir_output;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((~own & ~dir_q & IMPL & (pad_out_o ^ lat_q)) == 16'h0000);
  endproperty
  a_dir_output: assert property (p_dir_output)
    else $error("output pin not driven from latch");

  property p_input_only;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((~OUT_CAP & IMPL & (pad_oe_o ^ ~dir_q)) == 16'h0000);
  endproperty
  a_input_only: assert property (p_input_only)
    else $error("input-only sharer took the driver");

  property p_dir_reset;
    @(posedge clk_i)
      $rose(rst_n_i) |-> (dir_q == IMPL) && (pad_oe_o == own);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("pins not inputs after reset");

endmodule

// >>> tb/pad_model.sv
`timescale 1ns/1ps
module pad_model (
  input  wire logic [15:0] pad_out_i [5],
  input  wire logic [15:0] pad_oe_i  [5],
  input  wire logic [15:0] ext_i     [5],
  output logic      [15:0] pad_in_o  [5]
);
  // Driven bits loop back; released bits show the board level
  always_comb
  begin
    for (int p = 0; p < 5; p++)
    begin
      pad_in_o[p] = (pad_oe_i[p] & pad_out_i[p]) | (~pad_oe_i[p] & ext_i[p]);
    end
  end
endmodule

// >>> tb/tb_shared_parallel_io_ports.sv
`timescale 1ns/1ps
module tb_shared_parallel_io_ports;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [11:0] wb_adr  = 12'h000;
  logic [3:0]  wb_sel  = 4'h0;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [15:0] pad_in [5], pad_out [5], pad_oe [5], lvl [5];
  logic [15:0] pen [5], pdrv [5], pdat [5], ext [5];
  logic [15:0] dir_m [5], lat_m [5];
  logic [15:0] ana_m;
  int          n_fail = 0;
  int          compares = 0;

  always #2 clk_i = ~clk_i;

  shared_parallel_io_ports DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .pad_b_in_i(pad_in[0]), .pad_c_in_i(pad_in[1]), .pad_d_in_i(pad_in[2]),
    .pad_e_in_i(pad_in[3]), .pad_f_in_i(pad_in[4]),
    .pad_b_out_o(pad_out[0]), .pad_c_out_o(pad_out[1]),
    .pad_d_out_o(pad_out[2]), .pad_e_out_o(pad_out[3]),
    .pad_f_out_o(pad_out[4]),
    .pad_b_oe_o(pad_oe[0]), .pad_c_oe_o(pad_oe[1]), .pad_d_oe_o(pad_oe[2]),
    .pad_e_oe_o(pad_oe[3]), .pad_f_oe_o(pad_oe[4]),
    .periph_b_en_i(pen[0]), .periph_c_en_i(pen[1]), .periph_d_en_i(pen[2]),
    .periph_e_en_i(pen[3]), .periph_f_en_i(pen[4]),
    .periph_b_drive_i(pdrv[0]), .periph_c_drive_i(pdrv[1]),
    .periph_d_drive_i(pdrv[2]), .periph_e_drive_i(pdrv[3]),
    .periph_f_drive_i(pdrv[4]),
    .periph_b_out_i(pdat[0]), .periph_c_out_i(pdat[1]),
    .periph_d_out_i(pdat[2]), .periph_e_out_i(pdat[3]),
    .periph_f_out_i(pdat[4]),
    .pin_b_level_o(lvl[0]), .pin_c_level_o(lvl[1]), .pin_d_level_o(lvl[2]),
    .pin_e_level_o(lvl[3]), .pin_f_level_o(lvl[4])
  );

  pad_model u_pads (
    .pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_in_o(pad_in)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] own(int p);
    return pen[p] & pdrv[p] & gpio_pkg::OUT_CAP_MASK[p];
  endfunction

  function automatic logic [15:0] exp_oe(int p);
    return own(p) | ~dir_m[p];
  endfunction

  function automatic logic [15:0] exp_out(int p);
    return (own(p) & pdat[p]) | (~own(p) & lat_m[p]);
  endfunction

  function automatic logic [15:0] exp_pad(int p);
    return (exp_oe(p) & exp_out(p)) | (~exp_oe(p) & ext[p]);
  endfunction

  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n,
                                        logic [1:0] s);
    return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction

  // Classic single cycle; holds until ack, then releases for a cycle
  task automatic wb_xfer(input logic w, input logic [9:0] idx,
                         input logic [15:0] d, input logic [1:0] s,
                         output logic [15:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= {2'b00, s};
    wb_wdat <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    check({15'h0000, wb_ack}, 16'h0001);
    check(wb_rdat[31:16], 16'h0000);
    rd = wb_rdat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int p = 0; p < 5; p++)
    begin
      dir_m[p] = gpio_pkg::IMPL_MASK[p];
      lat_m[p] = 16'h0000;
    end
    ana_m = 16'h0000;
  endtask

  task automatic check_regs(int p);
    logic [15:0] rd;
    wb_xfer(1'b0, gpio_pkg::DIR_IDX[p], 16'h0000, 2'h3, rd);
    check(rd, dir_m[p]);
    wb_xfer(1'b0, gpio_pkg::LAT_IDX[p], 16'h0000, 2'h3, rd);
    check(rd, lat_m[p]);
  endtask

  task automatic check_pins(int p);
    logic [15:0] rd;
    logic [15:0] m;
    logic [15:0] a;
    m = gpio_pkg::IMPL_MASK[p];
    a = (p == gpio_pkg::ANA_PORT) ? ana_m : 16'h0000;
    repeat (6) @(posedge clk_i);
    check(pad_oe[p] & m, exp_oe(p) & m);
    check(pad_out[p] & m, exp_out(p) & m);
    check(lvl[p] & m, exp_pad(p) & m);
    wb_xfer(1'b0, gpio_pkg::PIN_IDX[p], 16'h0000, 2'h3, rd);
    check(rd, exp_pad(p) & m & ~a);
  endtask

  initial
  begin
    #40000;
    n_fail++;
    final_report();
  end

  initial
  begin
    logic [15:0] rd, d, l, a;
    logic [1:0]  s;
    int          p;
    void'($urandom(58157));
    for (int i = 0; i < 5; i++)
    begin
      pen[i] = 16'h0000;
      pdrv[i] = 16'h0000;
      pdat[i] = 16'h0000;
      ext[i] = 16'h0000;
    end
    do_reset();
    for (int i = 0; i < 5; i++)
      check_regs(i);
    wb_xfer(1'b0, 10'h000, 16'h0000, 2'h3, rd);
    check(rd, 16'h0000);
    $display("test reset_values done");
    for (int r = 0; r < 40; r++)
    begin
      p = $urandom_range(4);
      d = (r < 4) ? 16'h0000 : ((r < 6) ? 16'hFFFF : 16'($urandom));
      l = 16'($urandom);
      s = (r < 8) ? 2'h3 : 2'($urandom);
      a = 16'($urandom);
      @(posedge clk_i);
      pen[p]  <= (r < 4) ? 16'hFFFF : 16'($urandom);
      pdrv[p] <= (r < 4) ? 16'h0000 : 16'($urandom);
      pdat[p] <= 16'($urandom);
      ext[p]  <= 16'($urandom);
      if (p == gpio_pkg::ANA_PORT)
      begin
        wb_xfer(1'b1, gpio_pkg::ANA_IDX, a, 2'h3, rd);
        ana_m = a & gpio_pkg::IMPL_MASK[p];
        d = d | ana_m;
      end
      wb_xfer(1'b1, gpio_pkg::DIR_IDX[p], d, 2'h3, rd);
      dir_m[p] = d & gpio_pkg::IMPL_MASK[p];
      wb_xfer(1'b1, r[0] ? gpio_pkg::PIN_IDX[p] : gpio_pkg::LAT_IDX[p],
              l, s, rd);
      lat_m[p] = merge(lat_m[p], l, s) & gpio_pkg::IMPL_MASK[p];
      check_pins(p);
      check_regs(p);
    end
    $display("test random_port_traffic done");
    do_reset();
    for (int i = 0; i < 5; i++)
      check_regs(i);
    $display("test second_reset done");
    final_report();
  end
endmodule
